// file: rtl/sideband_pkg.sv
// package: constants and types shared by the sideband ends
// assumes a single 50 MHz clock on both ends
package sideband_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int ERR_PULSE_CYCLES = 16;
   localparam logic [4:0] ERR_PULSE_LAST = 5'h0F;
   localparam logic [4:0] ERR_CNT_ZERO = 5'h00;
   localparam logic [4:0] ERR_CNT_ONE = 5'h01;
   localparam int TRIP_DEG_C = 130;
   localparam logic [7:0] TRIP_TEMP = 8'h82;
   localparam logic [7:0] TEMP_RESET = 8'h00;
   localparam logic [3:0] GOOD_DELAY_LAST = 4'hF;
   localparam logic [3:0] GOOD_DELAY_ZERO = 4'h0;
   localparam logic [3:0] GOOD_DELAY_ONE = 4'h1;
   typedef enum logic [1:0] {err_idle, err_pulse, err_hold} err_state_t;
   typedef enum logic [1:0] {pwr_off, pwr_wait, pwr_good} pwr_state_t;
endpackage

// file: rtl/sideband_if.sv
// interface: sideband wires between the device and the board controller
// resolves the open-drain lines here from the enables: a line is low while any of its enables is set
interface sideband_if;
   logic catastrophic_error_n;
   logic over_temperature_n_dev_o;
   logic over_temperature_n_dev_oe;
   logic over_temperature_n_brd_o;
   logic over_temperature_n_brd_oe;
   logic over_temperature_n;
   logic thermal_shutdown_n_o;
   logic thermal_shutdown_n_oe;
   logic thermal_shutdown_n;
   logic regulator_fault;
   logic core_supply_good;
   logic sustain_supply_good;
   assign over_temperature_n = ~(over_temperature_n_dev_oe | over_temperature_n_brd_oe);
   assign thermal_shutdown_n = ~thermal_shutdown_n_oe;
   modport device (
      output catastrophic_error_n,
      output over_temperature_n_dev_o,
      output over_temperature_n_dev_oe,
      input over_temperature_n,
      output thermal_shutdown_n_o,
      output thermal_shutdown_n_oe,
      output regulator_fault,
      input core_supply_good,
      input sustain_supply_good
   );
   modport board (
      input catastrophic_error_n,
      output over_temperature_n_brd_o,
      output over_temperature_n_brd_oe,
      input over_temperature_n,
      input thermal_shutdown_n,
      input regulator_fault,
      output core_supply_good,
      output sustain_supply_good
   );
endinterface

// file: rtl/sideband_device.sv
// device end: error, over-temperature and thermal shutdown sideband logic
// assumes the board drives the power-good inputs cleanly and monotonically
// Function
// - machine-check error: sixteen-cycle active error pulse
// - internal error: hold error until reset
// - raise error on unrecoverable errors
// - drive over-temperature at maximum safe temperature
// - external over-temperature activates thermal control
// - above 130 C halt, assert shutdown
// - board keeps core good low until valid
// - power-good rises monotonically, no reversals
// - sustain good valid in run, suspend
// - regulator fault asserts with shutdown, halts
module sideband_device
   import sideband_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // internal events
   input wire logic machine_check_error_i,
   input wire logic internal_fatal_error_i,
   input wire logic [7:0] temperature_i,
   input wire logic tcc_enable_i,
   input wire logic regulator_fault_event_i,
   // status to the core
   output logic thermal_control_circuit_o,
   output logic halt_o,
   output logic powered_o,
   // link
   sideband_if.device link
);
   //------------------------------------------------
   // state
   //------------------------------------------------
   typedef struct packed {
      err_state_t err;
      logic [4:0] cnt;
      logic cat_n;
      logic hot_drive;
      logic [1:0] drive_dly;
      logic [1:0] hot_sync;
      logic [1:0] core_sync;
      logic [1:0] sus_sync;
      logic trip;
      logic vr_fault;
      logic thermal_control_circuit;
      logic halt;
      logic powered;
   } dev_state_t;
   dev_state_t s_reg;
   dev_state_t s_next;
   logic hot_ext;
   // own drive comes back through the synchroniser two cycles late
   assign hot_ext = ~s_reg.hot_sync[1] & ~s_reg.drive_dly[1];
   //------------------------------------------------
   // next state
   //------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.hot_sync = {s_reg.hot_sync[0], link.over_temperature_n};
      s_next.drive_dly = {s_reg.drive_dly[0], s_reg.hot_drive};
      s_next.core_sync = {s_reg.core_sync[0], link.core_supply_good};
      s_next.sus_sync = {s_reg.sus_sync[0], link.sustain_supply_good};
      s_next.powered = s_reg.core_sync[1] & s_reg.sus_sync[1];
      case (s_reg.err)
         err_idle: begin
            if (internal_fatal_error_i) begin
               s_next.err = err_hold;
            end else if (machine_check_error_i) begin
               s_next.err = err_pulse;
               s_next.cnt = ERR_CNT_ZERO;
            end
         end
         err_pulse: begin
            s_next.cnt = s_reg.cnt + ERR_CNT_ONE;
            if (internal_fatal_error_i) begin
               s_next.err = err_hold;
            end else if (s_reg.cnt == ERR_PULSE_LAST) begin
               s_next.err = err_idle;
            end
         end
         err_hold: s_next.err = err_hold;
         default: s_next.err = err_idle;
      endcase
      s_next.cat_n = ~((s_next.err == err_pulse) | (s_next.err == err_hold));
      s_next.hot_drive = tcc_enable_i & (temperature_i >= TRIP_TEMP);
      s_next.thermal_control_circuit = s_next.hot_drive | hot_ext;
      if (temperature_i > TRIP_TEMP) begin
         s_next.trip = 1'b1;
      end
      if (regulator_fault_event_i) begin
         s_next.vr_fault = 1'b1;
         s_next.trip = 1'b1;
      end
      s_next.halt = s_next.trip;
   end
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '{err: err_idle, cnt: ERR_CNT_ZERO, cat_n: 1'b1, hot_drive: 1'b0, drive_dly: 2'b00,
                    hot_sync: 2'b11, core_sync: 2'b00, sus_sync: 2'b00, trip: 1'b0,
                    vr_fault: 1'b0, thermal_control_circuit: 1'b0, halt: 1'b0, powered: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end
   //------------------------------------------------
   // outputs
   //------------------------------------------------
   assign link.catastrophic_error_n = s_reg.cat_n;
   assign link.over_temperature_n_dev_o = 1'b0;
   assign link.over_temperature_n_dev_oe = s_reg.hot_drive;
   assign link.thermal_shutdown_n_o = 1'b0;
   assign link.thermal_shutdown_n_oe = s_reg.trip;
   assign link.regulator_fault = s_reg.vr_fault;
   assign thermal_control_circuit_o = s_reg.thermal_control_circuit;
   assign halt_o = s_reg.halt;
   assign powered_o = s_reg.powered;
endmodule // sideband_device

// file: rtl/sideband_board.sv
// board end: power-good sequencing and over-temperature request
// assumes supply-valid inputs come from pins and need synchronising
module sideband_board
   import sideband_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // board requests
   input wire logic supplies_valid_i,
   input wire logic sustain_valid_i,
   input wire logic force_hot_i,
   // status
   output logic cat_error_o,
   output logic hot_seen_o,
   output logic shutdown_o,
   output logic vr_fault_o,
   // link
   sideband_if.board link
);
   //------------------------------------------------
   // state
   //------------------------------------------------
   typedef struct packed {
      pwr_state_t pwr;
      logic [3:0] dly;
      logic [1:0] sup_sync;
      logic [1:0] sus_sync;
      logic [1:0] cat_sync;
      logic [1:0] hot_sync;
      logic [1:0] trip_sync;
      logic [1:0] vr_sync;
      logic core_good;
      logic sus_good;
      logic hot;
      logic cat;
      logic hot_seen;
      logic shut;
      logic vr;
   } brd_state_t;
   brd_state_t s_reg;
   brd_state_t s_next;
   always_comb begin
      s_next = s_reg;
      s_next.sup_sync = {s_reg.sup_sync[0], supplies_valid_i};
      s_next.sus_sync = {s_reg.sus_sync[0], sustain_valid_i};
      s_next.cat_sync = {s_reg.cat_sync[0], link.catastrophic_error_n};
      s_next.hot_sync = {s_reg.hot_sync[0], link.over_temperature_n};
      s_next.trip_sync = {s_reg.trip_sync[0], link.thermal_shutdown_n};
      s_next.vr_sync = {s_reg.vr_sync[0], link.regulator_fault};
      case (s_reg.pwr)
         pwr_off: begin
            s_next.core_good = 1'b0;
            s_next.dly = GOOD_DELAY_ZERO;
            if (s_reg.sup_sync[1]) begin
               s_next.pwr = pwr_wait;
            end
         end
         pwr_wait: begin
            s_next.dly = s_reg.dly + GOOD_DELAY_ONE;
            if (!s_reg.sup_sync[1]) begin
               s_next.pwr = pwr_off;
            end else if (s_reg.dly == GOOD_DELAY_LAST) begin
               s_next.pwr = pwr_good;
               s_next.core_good = 1'b1;
            end
         end
         pwr_good: begin
            if (!s_reg.sup_sync[1]) begin
               s_next.pwr = pwr_off;
               s_next.core_good = 1'b0;
            end
         end
         default: s_next.pwr = pwr_off;
      endcase
      s_next.sus_good = s_reg.sus_sync[1];
      s_next.hot = force_hot_i;
      s_next.cat = ~s_reg.cat_sync[1];
      s_next.hot_seen = ~s_reg.hot_sync[1];
      s_next.shut = ~s_reg.trip_sync[1];
      s_next.vr = s_reg.vr_sync[1];
   end
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '{pwr: pwr_off, dly: GOOD_DELAY_ZERO, sup_sync: 2'b00, sus_sync: 2'b00,
                    cat_sync: 2'b11, hot_sync: 2'b11, trip_sync: 2'b11, vr_sync: 2'b00,
                    core_good: 1'b0, sus_good: 1'b0, hot: 1'b0, cat: 1'b0,
                    hot_seen: 1'b0, shut: 1'b0, vr: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end
   assign link.core_supply_good = s_reg.core_good;
   assign link.sustain_supply_good = s_reg.sus_good;
   assign link.over_temperature_n_brd_o = 1'b0;
   assign link.over_temperature_n_brd_oe = s_reg.hot;
   assign cat_error_o = s_reg.cat;
   assign hot_seen_o = s_reg.hot_seen;
   assign shutdown_o = s_reg.shut;
   assign vr_fault_o = s_reg.vr;
endmodule // sideband_board

// file: verification/sideband_properties.sv
// checker: timing of the sideband wires between device and board ends
// assumes one clock and an active-low asynchronous reset
module sideband_properties (
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // wires
   input wire logic catastrophic_error_n,
   input wire logic over_temperature_n_dev_o,
   input wire logic thermal_shutdown_n_o,
   input wire logic thermal_shutdown_n,
   input wire logic regulator_fault,
   input wire logic core_supply_good,
   input wire logic sustain_supply_good
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   logic [7:0] err_low_reg;
   logic [7:0] good_low_reg;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         err_low_reg <= 8'h00;
         good_low_reg <= 8'h00;
      end else begin
         err_low_reg <= catastrophic_error_n ? 8'h00 : err_low_reg + 8'h01;
         good_low_reg <= core_supply_good ? 8'h00 : good_low_reg + 8'h01;
      end
   end
   AST_PULSE_LEN: assert property ($rose(catastrophic_error_n) |-> err_low_reg == 8'h10)
      else $error("error pulse length wrong");
   AST_PULSE_HOLD: assert property ($fell(catastrophic_error_n) |=> !catastrophic_error_n [*8])
      else $error("error pulse cut short");
   AST_TRIP_STICKY: assert property (!thermal_shutdown_n |=> !thermal_shutdown_n)
      else $error("shutdown released");
   AST_FAULT_TRIP: assert property ($rose(regulator_fault) |-> ##[0:2] !thermal_shutdown_n)
      else $error("regulator fault without shutdown");
   AST_FAULT_STICKY: assert property ($rose(regulator_fault) |=> regulator_fault [*4])
      else $error("regulator fault released");
   AST_OPEN_DRAIN: assert property (!over_temperature_n_dev_o && !thermal_shutdown_n_o)
      else $error("open-drain data not low");
   AST_CORE_GOOD_LATE: assert property ($rose(core_supply_good) |-> good_low_reg >= 8'h0C)
      else $error("core good rose early");
   AST_SUSTAIN_STEADY: assert property ($rose(sustain_supply_good) |=> sustain_supply_good [*2])
      else $error("sustain good glitched");
   cover property ($rose(catastrophic_error_n));
   cover property ($fell(thermal_shutdown_n));
   cover property ($rose(core_supply_good));
endmodule // sideband_properties

// file: verification/error_thermal_powergood_sideband_test.sv
// testbench: device and board ends joined, checked against a rule model
// assumes package, interface and both ends are compiled first
module error_thermal_powergood_sideband_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic mce = 1'b0, ife = 1'b0, en = 1'b0, rfe = 1'b0, sup = 1'b0, sus = 1'b0, hot = 1'b0;
   logic [7:0] temp = 8'h00;
   logic thermal_control_circuit, halt, pwr, cat, seen, shut, vrf;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 32'h1210d8d9;
   int n, t, lows;
   sideband_if link ();
   sideband_device sideband_device_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .machine_check_error_i(mce), .internal_fatal_error_i(ife), .temperature_i(temp),
      .tcc_enable_i(en), .regulator_fault_event_i(rfe), .thermal_control_circuit_o(thermal_control_circuit),
      .halt_o(halt), .powered_o(pwr), .link(link));
   sideband_board sideband_board_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .supplies_valid_i(sup),
      .sustain_valid_i(sus), .force_hot_i(hot), .cat_error_o(cat), .hot_seen_o(seen),
      .shutdown_o(shut), .vr_fault_o(vrf), .link(link));
   sideband_properties sideband_properties_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .catastrophic_error_n(link.catastrophic_error_n),
      .over_temperature_n_dev_o(link.over_temperature_n_dev_o),
      .thermal_shutdown_n_o(link.thermal_shutdown_n_o),
      .thermal_shutdown_n(link.thermal_shutdown_n), .regulator_fault(link.regulator_fault),
      .core_supply_good(link.core_supply_good),
      .sustain_supply_good(link.sustain_supply_good));
   initial forever #10 mclk_i = ~mclk_i;
   always @(negedge mclk_i) if (link.catastrophic_error_n === 1'b0) lows++;
   // rule model of the error line: pulse length in base clock cycles, hold until reset
   int model_left = 0;
   bit model_hold = 1'b0;
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         model_left <= 0;
         model_hold <= 1'b0;
      end else begin
         if (model_left > 0) model_left <= model_left - 1;
         if (ife) begin
            model_hold <= 1'b1;
         end else if (mce && model_left == 0 && !model_hold) begin
            model_left <= sideband_pkg::ERR_PULSE_CYCLES;
         end
      end
   end
   always @(negedge mclk_i) begin
      if (nrst_i) check(link.catastrophic_error_n, (model_hold || model_left > 0) ? 8'h00 : 8'h01);
   end
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic go(input int k);
      tick(k);
      @(posedge mclk_i);
   endtask
   task automatic wait_pwr();
      n = 0;
      while (pwr !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      check(pwr, 1'b1);
      check(link.catastrophic_error_n, 1'b1);
      @(posedge mclk_i);
   endtask
   task automatic do_reset();
      temp <= 8'h00;
      nrst_i <= 1'b0;
      go(8);
      nrst_i <= 1'b1;
      wait_pwr();
   endtask
   task automatic pulse(input int gap);
      lows = 0;
      mce <= 1'b1;
      go(0);
      mce <= 1'b0;
      tick(gap);
      check(cat, 1'b1);
      @(posedge mclk_i);
      mce <= 1'b1;
      go(0);
      mce <= 1'b0;
      tick(30);
      check(8'(lows), 8'(sideband_pkg::ERR_PULSE_CYCLES));
      @(posedge mclk_i);
   endtask
   initial begin
      go(8);
      nrst_i <= 1'b1;
      tick(20);
      check(link.core_supply_good, 1'b0);
      @(posedge mclk_i);
      sup <= 1'b1;
      sus <= 1'b1;
      tick(10);
      check(link.core_supply_good, 1'b0);
      wait_pwr();
      check(link.sustain_supply_good, 1'b1);
      pulse(4 + {$random(seed)} % 8);
      pulse(4 + {$random(seed)} % 8);
      ife <= 1'b1;
      go(0);
      ife <= 1'b0;
      tick(40);
      check(link.catastrophic_error_n, 1'b0);
      check(cat, 1'b1);
      @(posedge mclk_i);
      do_reset();
      repeat (8) begin
         t = ($random(seed) & 1) ? 130 : {$random(seed)} % 131;
         n = $random(seed) & 1;
         temp <= 8'(t);
         en <= n[0];
         tick(3);
         check(link.over_temperature_n, (t == 130 && n[0]) ? 1'b0 : 1'b1);
         check(thermal_control_circuit, (t == 130 && n[0]) ? 1'b1 : 1'b0);
         check(link.thermal_shutdown_n, 1'b1);
         @(posedge mclk_i);
      end
      temp <= 8'h82;
      en <= 1'b1;
      tick(6);
      check(seen, 1'b1);
      @(posedge mclk_i);
      temp <= 8'h83;
      tick(6);
      check(link.thermal_shutdown_n, 1'b0);
      check(halt & shut, 1'b1);
      @(posedge mclk_i);
      do_reset();
      rfe <= 1'b1;
      go(0);
      rfe <= 1'b0;
      tick(6);
      check(link.regulator_fault & vrf, 1'b1);
      check(link.thermal_shutdown_n, 1'b0);
      @(posedge mclk_i);
      do_reset();
      hot <= 1'b1;
      tick(8);
      check(link.over_temperature_n, 1'b0);
      check(thermal_control_circuit, 1'b1);
      print_verdict();
   end
endmodule // error_thermal_powergood_sideband_test
